// >>> logic/sivu_defines.svh
// offsets, field positions, vectors and reset values of the six-source irq unit
`ifndef SIVU_DEFINES_SVH
`define SIVU_DEFINES_SVH

// register indices and byte addresses (index times four)
`define SIVU_CTL0_IDX     6'h0B
`define SIVU_CTL1_IDX     6'h1E
`define SIVU_CTL0_ADDR    {`SIVU_CTL0_IDX, 2'b00}
`define SIVU_CTL1_ADDR    {`SIVU_CTL1_IDX, 2'b00}
`define SIVU_STAT_ADDR    8'h80

// control register 0 fields
`define SIVU_GIE_BIT      0
`define SIVU_EN0_LSB      1
`define SIVU_FLAG0_LSB    4
// control register 1 fields
`define SIVU_EN1_LSB      0
`define SIVU_FLAG1_LSB    4

// reset values
`define SIVU_CTL_RESET    8'h00

// vectors in priority order
`define SIVU_VEC_CMP0     11'h004
`define SIVU_VEC_CMP1     11'h008
`define SIVU_VEC_PIN      11'h00C
`define SIVU_VEC_TMR0     11'h010
`define SIVU_VEC_TMR1     11'h014
`define SIVU_VEC_ADC      11'h018

// axi responses
`define SIVU_RESP_OKAY    2'h0
`define SIVU_RESP_SLVERR  2'h2

`endif

// >>> logic/sivu_pkg.sv
// types shared by the six-source irq unit
package sivu_pkg;

  typedef logic [10:0] sivu_vec_t;
  typedef logic [5:0]  sivu_mask_t;

  typedef enum logic [2:0] {
    SIVU_SRC_CMP0,
    SIVU_SRC_CMP1,
    SIVU_SRC_PIN,
    SIVU_SRC_TMR0,
    SIVU_SRC_TMR1,
    SIVU_SRC_ADC,
    SIVU_SRC_NONE
  } sivu_src_t;

endpackage

// >>> logic/sivu_prio.sv
// fixed-priority picker and vector lookup for the six sources
`timescale 1ns/1ps
`include "sivu_defines.svh"

module sivu_prio (
  input  wire sivu_pkg::sivu_mask_t req,    // armed requests, bit 0 highest
  output wire logic                 hit,    // any request armed
  output wire sivu_pkg::sivu_mask_t onehot, // winning source
  output wire sivu_pkg::sivu_src_t  src,    // winning source index
  output wire sivu_pkg::sivu_vec_t  vec     // winning vector
);

  function automatic sivu_pkg::sivu_src_t pick(input sivu_pkg::sivu_mask_t r);
    sivu_pkg::sivu_src_t s;
    s = sivu_pkg::SIVU_SRC_NONE;
    if (r[5]) s = sivu_pkg::SIVU_SRC_ADC;
    if (r[4]) s = sivu_pkg::SIVU_SRC_TMR1;
    if (r[3]) s = sivu_pkg::SIVU_SRC_TMR0;
    if (r[2]) s = sivu_pkg::SIVU_SRC_PIN;
    if (r[1]) s = sivu_pkg::SIVU_SRC_CMP1;
    if (r[0]) s = sivu_pkg::SIVU_SRC_CMP0;
    return s;
  endfunction

  function automatic sivu_pkg::sivu_vec_t vec_of(input sivu_pkg::sivu_src_t s);
    sivu_pkg::sivu_vec_t v;
    case (s)
      sivu_pkg::SIVU_SRC_CMP0: v = `SIVU_VEC_CMP0;
      sivu_pkg::SIVU_SRC_CMP1: v = `SIVU_VEC_CMP1;
      sivu_pkg::SIVU_SRC_PIN:  v = `SIVU_VEC_PIN;
      sivu_pkg::SIVU_SRC_TMR0: v = `SIVU_VEC_TMR0;
      sivu_pkg::SIVU_SRC_TMR1: v = `SIVU_VEC_TMR1;
      sivu_pkg::SIVU_SRC_ADC:  v = `SIVU_VEC_ADC;
      default:                 v = 11'h000;
    endcase
    return v;
  endfunction

  assign src    = pick(req);
  assign hit    = |req;
  assign vec    = vec_of(src);
  assign onehot = req & ~(req - 6'h01);

endmodule

// >>> logic/sivu_unit.sv
// six-source vectored interrupt unit with axi4-lite register access
//
// What this block does
// - with global enable clear, requests only set flags, never acknowledged
// - no acknowledge while the return stack is full
// - acknowledge tells core to push only the program counter, then vector
// - comparator 0 falling edge sets flag bit 4 of control 0; vector 04H
// - comparator 1 falling edge sets flag bit 5 of control 0; vector 08H
// - external pin falling edge sets flag bit 6 of control 0; vector 0CH
// - timer 0 overflow sets flag bit 4 of control 1; vector 010H
// - timer 1 overflow sets flag bit 5 of control 1; vector 014H
// - conversion complete sets flag bit 6 of control 1; vector 018H
// - take only with source enable, global enable, flag set, stack not full
// - acknowledge clears that source flag and the global enable
// - control 0: global enable bit 0, three source enables bits 1 to 3
// - control 1: three source enables bits 0 to 2; bits 3, 7 read zero
// - return from interrupt sets global enable; plain return leaves it
// - software re-enabling inside a routine allows nested acknowledge
// - requests are acknowledged only on a phase-two pulse
// - fixed priority: cmp0, cmp1, pin, timer 0, timer 1, converter
// - flags stay set until serviced or cleared; enables never block setting
// - every source event raises a wake-up request
`timescale 1ns/1ps
`include "sivu_defines.svh"

module sivu_unit (
  input  wire logic        aclk,              // system clock
  input  wire logic        aresetn,           // synchronous reset, active low
  input  wire logic        cen,               // clock enable, freezes state when low
  // axi4-lite write address
  input  wire logic        s_axi_awvalid,     // write address valid
  output wire logic        s_axi_awready,     // write address ready
  input  wire logic [7:0]  s_axi_awaddr,      // write byte address
  // axi4-lite write data
  input  wire logic        s_axi_wvalid,      // write data valid
  output wire logic        s_axi_wready,      // write data ready
  input  wire logic [31:0] s_axi_wdata,       // write data
  input  wire logic [3:0]  s_axi_wstrb,       // write byte strobes
  // axi4-lite write response
  output wire logic        s_axi_bvalid,      // write response valid
  input  wire logic        s_axi_bready,      // write response ready
  output wire logic [1:0]  s_axi_bresp,       // write response code
  // axi4-lite read address
  input  wire logic        s_axi_arvalid,     // read address valid
  output wire logic        s_axi_arready,     // read address ready
  input  wire logic [7:0]  s_axi_araddr,      // read byte address
  // axi4-lite read data
  output wire logic        s_axi_rvalid,      // read data valid
  input  wire logic        s_axi_rready,      // read data ready
  output wire logic [31:0] s_axi_rdata,       // read data
  output wire logic [1:0]  s_axi_rresp,       // read response code
  // request sources
  input  wire logic        cmp0_out,          // comparator 0 output level
  input  wire logic        cmp1_out,          // comparator 1 output level
  input  wire logic        ext_irq_pin,       // external interrupt pin level
  input  wire logic        tmr0_ovf,          // timer 0 overflow pulse
  input  wire logic        tmr1_ovf,          // timer 1 overflow pulse
  input  wire logic        adc_done,          // conversion complete pulse
  // core sequencer
  input  wire logic        phase_two_pulse,   // instruction phase-two pulse
  input  wire logic        stack_full,        // return stack has no free level
  input  wire logic        return_from_irq,   // return-from-interrupt executed
  output logic             irq_ack,           // push pc and branch, one cycle
  output sivu_pkg::sivu_vec_t irq_vector,     // branch target with irq_ack
  output sivu_pkg::sivu_src_t irq_source,     // source of last acknowledge
  output logic             irq_pending,       // an armed request waits
  output logic             wake_req,          // wake from power-down, one cycle
  output logic             global_irq_enable  // global enable state
);

  // register state
  sivu_pkg::sivu_mask_t req_flag;
  sivu_pkg::sivu_mask_t irq_en;
  logic                 cmp0_prev;
  logic                 cmp1_prev;
  logic                 pin_prev;

  // axi state
  logic                 aw_held;
  logic [7:0]           aw_addr;
  logic                 w_held;
  logic [31:0]          w_data;
  logic [3:0]           w_strb;
  logic                 bvalid;
  logic [1:0]           bresp;
  logic                 rvalid;
  logic [31:0]          rdata;
  logic [1:0]           rresp;

  // source events
  wire logic cmp0_fall;
  wire logic cmp1_fall;
  wire logic pin_fall;
  wire sivu_pkg::sivu_mask_t src_event;

  assign cmp0_fall = cmp0_prev & ~cmp0_out;
  assign cmp1_fall = cmp1_prev & ~cmp1_out;
  assign pin_fall  = pin_prev & ~ext_irq_pin;
  assign src_event = {adc_done,
                      tmr1_ovf,
                      tmr0_ovf,
                      pin_fall,
                      cmp1_fall,
                      cmp0_fall};

  // arbitration
  wire sivu_pkg::sivu_mask_t armed;
  wire logic                 win_hit;
  wire sivu_pkg::sivu_mask_t win_onehot;
  wire sivu_pkg::sivu_src_t  win_src;
  wire sivu_pkg::sivu_vec_t  win_vec;
  wire logic                 take;
  wire sivu_pkg::sivu_mask_t ack_clr;

  assign armed = req_flag & irq_en & {6{global_irq_enable}};

  sivu_prio u_prio (
    .req    (armed),
    .hit    (win_hit),
    .onehot (win_onehot),
    .src    (win_src),
    .vec    (win_vec)
  );

  // sampled on phase two, blocked by full stack or cleared global enable
  assign take    = cen & phase_two_pulse & win_hit & ~stack_full;
  assign ack_clr = take ? win_onehot : 6'h00;

  // register select: bit 0 control 0, bit 1 control 1, bit 2 status
  function automatic logic [2:0] reg_sel(input logic [7:0] addr);
    logic [2:0] sel;
    sel[0] = (addr == `SIVU_CTL0_ADDR);
    sel[1] = (addr == `SIVU_CTL1_ADDR);
    sel[2] = (addr == `SIVU_STAT_ADDR);
    return sel;
  endfunction

  // axi write decode
  wire logic       wr_go;
  wire logic [2:0] wr_sel;
  wire logic       wr_lane0;
  wire logic       wr_ctl0;
  wire logic       wr_ctl1;
  wire logic       wr_stat;
  wire logic       wr_known;

  assign wr_go    = cen & aw_held & w_held & ~bvalid;
  assign wr_sel   = reg_sel(aw_addr);
  assign wr_lane0 = wr_go & w_strb[0];
  assign wr_ctl0  = wr_lane0 & wr_sel[0];
  assign wr_ctl1  = wr_lane0 & wr_sel[1];
  assign wr_stat  = wr_sel[2];
  assign wr_known = |wr_sel;

  assign s_axi_awready = cen & ~aw_held & ~bvalid;
  assign s_axi_wready  = cen & ~w_held & ~bvalid;
  assign s_axi_bvalid  = bvalid;
  assign s_axi_bresp   = bresp;

  // software view of flags and enables
  wire sivu_pkg::sivu_mask_t sw_wr;
  wire sivu_pkg::sivu_mask_t sw_flag;
  wire sivu_pkg::sivu_mask_t sw_en;

  assign sw_wr   = {{3{wr_ctl1}}, {3{wr_ctl0}}};
  assign sw_flag = {w_data[`SIVU_FLAG1_LSB +: 3], w_data[`SIVU_FLAG0_LSB +: 3]};
  assign sw_en   = {w_data[`SIVU_EN1_LSB +: 3], w_data[`SIVU_EN0_LSB +: 3]};

  // flag and enable cells, one per source
  genvar gi;
  generate
    for (gi = 0; gi < 6; gi++) begin : g_src
      wire logic next_flag;
      // a source event beats any clear in the same cycle
      assign next_flag = src_event[gi]
                       | (sw_wr[gi] ? sw_flag[gi]
                                    : (req_flag[gi] & ~ack_clr[gi]));
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          req_flag[gi] <= 1'b0;
          irq_en[gi]   <= 1'b0;
        end else if (cen) begin
          req_flag[gi] <= next_flag;
          if (sw_wr[gi]) begin
            irq_en[gi] <= sw_en[gi];
          end
        end
      end
    end
  endgenerate

  // global enable
  wire logic next_gie;

  assign next_gie = take            ? 1'b0
                  : return_from_irq ? 1'b1
                  : wr_ctl0         ? w_data[`SIVU_GIE_BIT]
                  : global_irq_enable;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      global_irq_enable <= 1'b0;
    end else if (cen) begin
      global_irq_enable <= next_gie;
    end
  end

  // edge history; start low so a low level after reset is no edge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmp0_prev <= 1'b0;
      cmp1_prev <= 1'b0;
      pin_prev  <= 1'b0;
    end else if (cen) begin
      cmp0_prev <= cmp0_out;
      cmp1_prev <= cmp1_out;
      pin_prev  <= ext_irq_pin;
    end
  end

  // core handshake: only the pc is pushed, status is left to software
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_ack    <= 1'b0;
      irq_vector <= 11'h000;
      irq_source <= sivu_pkg::SIVU_SRC_NONE;
    end else if (cen) begin
      irq_ack <= take;
      if (take) begin
        irq_vector <= win_vec;
        irq_source <= win_src;
      end
    end
  end

  // wake and pending indications
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wake_req    <= 1'b0;
      irq_pending <= 1'b0;
    end else if (cen) begin
      wake_req    <= |src_event;
      irq_pending <= win_hit & ~take;
    end
  end

  // axi write channel capture and response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr <= 8'h00;
    end else if (cen) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (wr_go) begin
        aw_held <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else if (cen) begin
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (wr_go) begin
        w_held <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp  <= `SIVU_RESP_OKAY;
    end else if (cen) begin
      if (wr_go) begin
        bvalid <= 1'b1;
        bresp  <= wr_known ? `SIVU_RESP_OKAY : `SIVU_RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // read decode; unused bits read as zero
  wire logic [7:0]  ctl0_view;
  wire logic [7:0]  ctl1_view;
  wire logic [31:0] stat_view;
  wire logic [2:0]  rd_sel;
  wire logic        rd_ctl0;
  wire logic        rd_ctl1;
  wire logic        rd_stat;
  wire logic        rd_known;
  wire logic [31:0] rd_value;
  wire logic        rd_go;

  assign ctl0_view = {1'b0, req_flag[2:0], irq_en[2:0],
                      global_irq_enable};
  assign ctl1_view = {1'b0, req_flag[5:3], 1'b0, irq_en[5:3]};
  assign stat_view = {7'h00, stack_full, 7'h00, irq_pending,
                      5'h00, irq_vector};

  assign rd_sel   = reg_sel(s_axi_araddr);
  assign rd_ctl0  = rd_sel[0];
  assign rd_ctl1  = rd_sel[1];
  assign rd_stat  = rd_sel[2];
  assign rd_known = |rd_sel;
  assign rd_value = rd_ctl0 ? {24'h00_0000, ctl0_view}
                  : rd_ctl1 ? {24'h00_0000, ctl1_view}
                  : rd_stat ? stat_view
                  : 32'h0000_0000;
  assign rd_go    = s_axi_arvalid & s_axi_arready;

  assign s_axi_arready = cen & ~rvalid;
  assign s_axi_rvalid  = rvalid;
  assign s_axi_rdata   = rdata;
  assign s_axi_rresp   = rresp;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata  <= 32'h0000_0000;
      rresp  <= `SIVU_RESP_OKAY;
    end else if (cen) begin
      if (rd_go) begin
        rvalid <= 1'b1;
        rdata  <= rd_value;
        rresp  <= rd_known ? `SIVU_RESP_OKAY : `SIVU_RESP_SLVERR;
      end else if (s_axi_rready) begin
        rvalid <= 1'b0;
      end
    end
  end

endmodule

// >>> tb/sivu_core_model.sv
// core sequencer and return stack model
`timescale 1ns/1ps
module sivu_core_model #(
  parameter int DEPTH = 2  // stack levels
) (
  input  wire logic aclk,            // clock
  input  wire logic aresetn,         // reset, low
  input  wire logic irq_ack,         // push pc
  input  wire logic ret_cmd,         // bench asks a return
  output logic      phase_two_pulse, // one cycle in four
  output logic      stack_full,      // no free level
  output logic      return_from_irq  // pop, re-enable
);
  logic [1:0] phase;
  int         depth;
  logic       pop;
  assign pop = ret_cmd && depth > 0;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      phase <= 2'h0;
      depth <= 0;
      return_from_irq <= 1'b0;
    end else begin
      phase <= phase + 2'h1;
      depth <= depth + int'(irq_ack) - int'(pop);
      return_from_irq <= pop;
    end
  end
  assign phase_two_pulse = (phase == 2'h3);
  assign stack_full = (depth >= DEPTH);
endmodule

// >>> tb/sivu_unit_checker.sv
// port assertions for the six-source irq unit
`timescale 1ns/1ps
module sivu_unit_checker (
  input wire logic                aclk,              // clock
  input wire logic                aresetn,           // reset, low
  input wire logic                cen,               // clock enable
  input wire logic                phase_two_pulse,   // phase pulse
  input wire logic                stack_full,        // stack full
  input wire logic                return_from_irq,   // return pulse
  input wire logic                tmr0_ovf,          // timer 0 event
  input wire logic                tmr1_ovf,          // timer 1 event
  input wire logic                adc_done,          // converter event
  input wire logic                irq_ack,           // acknowledge
  input wire sivu_pkg::sivu_vec_t irq_vector,        // vector
  input wire sivu_pkg::sivu_src_t irq_source,        // source
  input wire logic                wake_req,          // wake pulse
  input wire logic                global_irq_enable  // global enable
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_ack_pulse;
    irq_ack ##1 !irq_ack;
  endsequence
  a_ack_single: assert property (irq_ack |-> s_ack_pulse)
    else $error("ack wider than one cycle");
  a_ack_cause: assert property (irq_ack |->
    $past(cen && phase_two_pulse && global_irq_enable && !stack_full))
    else $error("ack without a qualified phase pulse");
  a_full_blocks: assert property (stack_full |=> !irq_ack)
    else $error("ack while stack full");
  a_gie_blocks: assert property (!global_irq_enable |=> !irq_ack)
    else $error("ack with global enable clear");
  a_ack_clr_gie: assert property (irq_ack |-> !global_irq_enable)
    else $error("global enable kept on ack");
  a_vec_map: assert property (irq_ack |->
    irq_vector == {6'h00, 3'(irq_source) + 3'h1, 2'b00})
    else $error("vector does not match source");
  a_return_from_irq_gie: assert property (
    return_from_irq && cen && !global_irq_enable |=> global_irq_enable)
    else $error("return did not set global enable");
  a_wake_pulse: assert property (
    cen && (tmr0_ovf || tmr1_ovf || adc_done) |=> wake_req)
    else $error("event without wake pulse");
endmodule

bind sivu_unit sivu_unit_checker sivu_unit_checker_inst (.aclk, .aresetn, .cen,
  .phase_two_pulse, .stack_full, .return_from_irq, .tmr0_ovf, .tmr1_ovf, .adc_done,
  .irq_ack, .irq_vector, .irq_source, .wake_req, .global_irq_enable);

// >>> tb/test_six_source_vectored_irq_unit.sv
// self-checking bench of the six-source irq unit
`timescale 1ns/1ps
`include "sivu_defines.svh"
module test_six_source_vectored_irq_unit;
  logic aclk, aresetn, cen, ret_cmd, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready, cmp0_out, cmp1_out, ext_irq_pin, tmr0_ovf;
  logic tmr1_ovf, adc_done, phase_two_pulse, stack_full, return_from_irq, irq_ack;
  logic irq_pending, wake_req, global_irq_enable;
  logic [7:0]          s_axi_awaddr, s_axi_araddr;
  logic [31:0]         s_axi_wdata, s_axi_rdata;
  logic [3:0]          s_axi_wstrb;
  logic [1:0]          s_axi_bresp, s_axi_rresp;
  sivu_pkg::sivu_vec_t irq_vector;
  sivu_pkg::sivu_src_t irq_source;
  logic [5:0]          pend;
  int                  err_count, checks, acks, wakes, n, depth, seed, tmp;
  int                  ord[6];

  sivu_unit sivu_unit_inst (.*);
  sivu_core_model #(.DEPTH(2)) sivu_core_model_inst (.*);

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  always @(negedge aclk) begin
    if (irq_ack === 1'b1) acks++;
    if (wake_req === 1'b1) wakes++;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    bit da, dw, ta, tw;
    da = 0;
    dw = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(da && dw)) begin
      @(negedge aclk);
      ta = s_axi_awready && !da;
      tw = s_axi_wready && !dw;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      da |= ta;
      dw |= tw;
    end
    do @(negedge aclk); while (s_axi_bvalid !== 1'b1);
    chk(s_axi_bresp, `SIVU_RESP_OKAY);
    @(posedge aclk);
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(negedge aclk); while (s_axi_arready !== 1'b1);
    @(posedge aclk);
    s_axi_arvalid <= 1'b0;
    do @(negedge aclk); while (s_axi_rvalid !== 1'b1);
    chk(s_axi_rdata, e);
    chk(s_axi_rresp, er);
    @(posedge aclk);
    s_axi_rready <= 1'b0;
  endtask

  task automatic fire(input int s);
    @(posedge aclk);
    case (s)
      0: cmp0_out <= 1'b0;
      1: cmp1_out <= 1'b0;
      2: ext_irq_pin <= 1'b0;
      3: tmr0_ovf <= 1'b1;
      4: tmr1_ovf <= 1'b1;
      default: adc_done <= 1'b1;
    endcase
    @(posedge aclk);
    {tmr0_ovf, tmr1_ovf, adc_done} <= 3'h0;
    repeat (3) @(posedge aclk);
  endtask

  task automatic ret();
    @(posedge aclk);
    ret_cmd <= 1'b1;
    @(posedge aclk);
    ret_cmd <= 1'b0;
    depth--;
  endtask

  function automatic logic [31:0] exp0();
    return {25'h0, pend[2:0], 4'hE};
  endfunction

  function automatic logic [31:0] exp1();
    return {25'h0, pend[5:3], 4'h7};
  endfunction

  task automatic print_verdict();
    $display("checks=%0d err_count=%0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    #100us;
    err_count++;
    print_verdict();
  end

  initial begin
    {aresetn, ret_cmd, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 5'h00;
    {s_axi_arvalid, s_axi_rready, tmr0_ovf, tmr1_ovf, adc_done} = 5'h00;
    {cen, cmp0_out, cmp1_out, ext_irq_pin} = 4'hF;
    {s_axi_awaddr, s_axi_araddr, s_axi_wstrb} = 20'h00000;
    s_axi_wdata = 32'h0;
    pend = 6'h00;
    seed = $urandom(95225);
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`SIVU_CTL0_ADDR, 32'h0, `SIVU_RESP_OKAY);
    rd(`SIVU_CTL1_ADDR, 32'h0, `SIVU_RESP_OKAY);
    rd(8'h40, 32'h0, `SIVU_RESP_SLVERR);
    wr(`SIVU_STAT_ADDR, $urandom, 4'hF);
    rd(`SIVU_STAT_ADDR, 32'h0, `SIVU_RESP_OKAY);
    wr(`SIVU_CTL0_ADDR, 32'hFFFFFF8E, 4'hF);
    wr(`SIVU_CTL1_ADDR, 32'h0000008F, 4'hF);
    wr(`SIVU_CTL1_ADDR, 32'h0, 4'hE);
    rd(`SIVU_CTL0_ADDR, exp0(), `SIVU_RESP_OKAY);
    rd(`SIVU_CTL1_ADDR, exp1(), `SIVU_RESP_OKAY);
    foreach (ord[i]) ord[i] = i;
    for (int i = 5; i > 0; i--) begin
      n = $urandom % (i + 1);
      tmp = ord[i];
      ord[i] = ord[n];
      ord[n] = tmp;
    end
    foreach (ord[i]) begin
      fire(ord[i]);
      pend[ord[i]] = 1'b1;
      rd(`SIVU_CTL0_ADDR, exp0(), `SIVU_RESP_OKAY);
      rd(`SIVU_CTL1_ADDR, exp1(), `SIVU_RESP_OKAY);
    end
    chk(wakes, 6);
    chk(acks, 0);
    n = acks;
    wr(`SIVU_CTL0_ADDR, exp0() | 32'h1, 4'hF);
    for (int k = 0; k < 6; k++) begin
      for (int t = 0; t < 60 && acks == n; t++) @(negedge aclk);
      n++;
      depth++;
      pend[k] = 1'b0;
      chk(acks, n);
      chk(irq_vector, (k + 1) * 4);
      chk(irq_source, k);
      rd(`SIVU_CTL0_ADDR, exp0(), `SIVU_RESP_OKAY);
      rd(`SIVU_CTL1_ADDR, exp1(), `SIVU_RESP_OKAY);
      if (k < 5) begin
        wr(`SIVU_CTL0_ADDR, exp0() | 32'h1, 4'hF);
        if (depth == 2) begin
          repeat (12) @(negedge aclk);
          chk(acks, n);
          rd(`SIVU_STAT_ADDR, 32'h01010000 | ((k + 1) * 4), `SIVU_RESP_OKAY);
          ret();
        end
      end
    end
    rd(`SIVU_STAT_ADDR, 32'h01000018, `SIVU_RESP_OKAY);
    ret();
    repeat (4) @(negedge aclk);
    chk(global_irq_enable, 1'b1);
    // frozen cycle: a timer event must leave no trace
    @(posedge aclk);
    cen <= 1'b0;
    tmr0_ovf <= 1'b1;
    @(posedge aclk);
    cen <= 1'b1;
    tmr0_ovf <= 1'b0;
    repeat (2) @(negedge aclk);
    chk(wakes, 6);
    rd(`SIVU_CTL1_ADDR, exp1(), `SIVU_RESP_OKAY);
    rd(`SIVU_STAT_ADDR, 32'h00000018, `SIVU_RESP_OKAY);
    print_verdict();
  end
endmodule
